// ===== src/tsq_regs.sv
// trigger sequencer parameter bank with a small step executor
//
// Notes on behaviour
// RL1: broadcast bit 4 pulses oc unit 1 clock
// RL2: bits 3..0 pulse oc units 4..1 sync
// RL3: only control option 1111 reads broadcast enables
// RL4: bank read-only while enabled and running, except the control register
// RL5: timer 0 limit, 16 bits, reset zero
// RL6: timer 1 limit, 16 bits, reset zero
// RL7: step with delay lasts limit plus one
// RL8: counter 0 limit drives counter 0 jump
// RL9: counter 1 limit drives counter 1 jump
// RL10: hold value copied into selected target
// RL11: adjust value added into selected target
// RL12: literal sent to channel select on command
// RL13: pointer five bits, upper bits read zero
// RL14: pair word: odd step high, even low
// RL15: sixteen queue words, cleared at reset
// RL16: start fetches from pointer, runs in order
// RL17: counter jump increments and loads when unequal
// RL18: locked writes are dropped silently
`timescale 1ns/10ps
`default_nettype none
module tsq_regs #(
  parameter int unsigned QDEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // trigger outputs
  output logic oc_unit1_clock_pulse,
  output logic [3:0] oc_sync_pulse,
  output logic chs_strobe,
  output logic [15:0] converter_channel_select,
  // timer match events from the core timers
  input wire logic timer0_match,
  input wire logic timer1_match,
  // limit values for the two core timers
  output logic [15:0] timer0_limit_q,
  output logic [15:0] timer1_limit_q
);
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    tsq_pkg::tsq_regs_t r;
    logic en;
    logic run;
    logic [4:0] qptr;
    tsq_pkg::tsq_seq_t st;
    logic sd_on;
    logic [15:0] dcnt;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [1:0] wtmr;
    tsq_pkg::tsq_out_t o;
    logic wreq;
    logic [31:0] rdata;
    logic [15:0] t0q;
    logic [15:0] t1q;
  } tsq_state_t;

  tsq_state_t s_ff, nxt_s;
  logic locked;
  logic acc;
  logic [15:0] wd;
  logic q_wr;
  logic [15:0] q_rd;
  logic [7:0] step;
  logic [3:0] cmd;
  logic [3:0] opt;
  logic [4:0] tgt5;
  logic [15:0] src;
  logic [15:0] cur;
  logic [15:0] newv;
  logic [4:0] qinc;

  assign locked = s_ff.en && s_ff.run; // see RL4
  assign acc = (avs_read || avs_write) && s_ff.wreq;
  // no partial writes on 16-bit registers: low two lanes carry the word
  assign wd = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
               avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
  assign q_wr = acc && avs_write && !locked &&
                avs_address[7:6] == tsq_pkg::OFF_QUE0[7:6]; // see RL18
  assign cmd = step[7:4];
  assign opt = step[3:0];
  assign tgt5 = {cmd[0], opt};
  // explicit wrap: a modulo by a full 5-bit depth would divide by zero
  assign qinc = (s_ff.qptr == 5'(QDEPTH - 1)) ? 5'h00
                                               : 5'(s_ff.qptr + 5'h01);

  //////////////////////////////////////////////////////////////////////////
  tsq_step_queue #(.NREG(tsq_pkg::QUE_REGS)) u_queue (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(q_wr),
    .wr_idx(avs_address[5:2]),
    .wr_data(wd),
    .rd_idx(avs_address[5:2]),
    .rd_data(q_rd),
    .step_idx(s_ff.qptr),
    .step_byte(step)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    src = 16'h0000;
    cur = 16'h0000;
    newv = 16'h0000;
    nxt_s.o.oc1_clk = 1'b0;
    nxt_s.o.oc_sync = 4'h0;
    nxt_s.o.chs_stb = 1'b0;
    nxt_s.wreq = 1'b1;
    // bus: one wait cycle, answer registered
    if (acc) begin
      nxt_s.wreq = 1'b0;
      nxt_s.rdata = tsq_pkg::UNMAPPED_RD;
      if (avs_read) begin
        case (avs_address)
          tsq_pkg::OFF_CTRL: nxt_s.rdata = {16'h0000, s_ff.en, 7'h00,
                                            s_ff.run, 7'h00};
          tsq_pkg::OFF_BTE: nxt_s.rdata = {16'h0000, s_ff.r.bte};
          tsq_pkg::OFF_T0LIM: nxt_s.rdata = {16'h0000, s_ff.r.t0lim};
          tsq_pkg::OFF_T1LIM: nxt_s.rdata = {16'h0000, s_ff.r.t1lim};
          tsq_pkg::OFF_SDLIM: nxt_s.rdata = {16'h0000, s_ff.r.sdlim};
          tsq_pkg::OFF_C0LIM: nxt_s.rdata = {16'h0000, s_ff.r.c0lim};
          tsq_pkg::OFF_C1LIM: nxt_s.rdata = {16'h0000, s_ff.r.c1lim};
          tsq_pkg::OFF_HOLD: nxt_s.rdata = {16'h0000, s_ff.r.hold};
          tsq_pkg::OFF_ADJ: nxt_s.rdata = {16'h0000, s_ff.r.adj};
          tsq_pkg::OFF_LIT: nxt_s.rdata = {16'h0000, s_ff.r.lit};
          tsq_pkg::OFF_QPTR: nxt_s.rdata = {27'h0, s_ff.qptr}; // see RL13
          tsq_pkg::OFF_STAT: nxt_s.rdata = {13'h0, s_ff.st, s_ff.c1};
          default: begin
            if (avs_address[7:6] == tsq_pkg::OFF_QUE0[7:6]) begin
              nxt_s.rdata = {16'h0000, q_rd};
            end
          end
        endcase
      end else if (avs_address == tsq_pkg::OFF_CTRL) begin
        // control stays writable so software can stop the sequencer
        nxt_s.en = wd[tsq_pkg::CTRL_EN_BIT];
        nxt_s.run = wd[tsq_pkg::CTRL_RUN_BIT] && s_ff.en;
        if (!wd[tsq_pkg::CTRL_RUN_BIT]) begin
          nxt_s.st = tsq_pkg::ST_IDLE;
        end
      end else if (!locked) begin // see RL4 RL18
        case (avs_address)
          tsq_pkg::OFF_BTE: nxt_s.r.bte = wd;
          tsq_pkg::OFF_T0LIM: nxt_s.r.t0lim = wd; // see RL5
          tsq_pkg::OFF_T1LIM: nxt_s.r.t1lim = wd; // see RL6
          tsq_pkg::OFF_SDLIM: nxt_s.r.sdlim = wd;
          tsq_pkg::OFF_C0LIM: nxt_s.r.c0lim = wd;
          tsq_pkg::OFF_C1LIM: nxt_s.r.c1lim = wd;
          tsq_pkg::OFF_HOLD: nxt_s.r.hold = wd; // see RL10
          tsq_pkg::OFF_ADJ: nxt_s.r.adj = wd; // see RL11
          tsq_pkg::OFF_LIT: nxt_s.r.lit = wd; // see RL12
          tsq_pkg::OFF_QPTR: nxt_s.qptr = wd[tsq_pkg::QPTR_W-1:0];
          default: nxt_s.qptr = s_ff.qptr;
        endcase
      end
    end
    // sequencer
    if (!locked) begin
      nxt_s.st = tsq_pkg::ST_IDLE;
    end else begin
      case (s_ff.st)
        tsq_pkg::ST_IDLE: begin
          nxt_s.st = tsq_pkg::ST_EXEC; // see RL16
        end
        tsq_pkg::ST_EXEC: begin
          nxt_s.qptr = qinc;
          nxt_s.st = tsq_pkg::ST_EXEC;
          if (cmd == tsq_pkg::CMD_CTRL) begin
            case (opt)
              tsq_pkg::OPT_SD_OFF: nxt_s.sd_on = 1'b0;
              tsq_pkg::OPT_SD_ON: nxt_s.sd_on = 1'b1;
              4'h8: nxt_s.wtmr = 2'b01;
              4'h9: nxt_s.wtmr = 2'b10;
              tsq_pkg::OPT_C0_CHS: begin
                nxt_s.o.chs_stb = 1'b1;
                nxt_s.o.chs_val = s_ff.r.c0lim;
              end
              tsq_pkg::OPT_C1_CHS: begin
                nxt_s.o.chs_stb = 1'b1;
                nxt_s.o.chs_val = s_ff.r.c1lim;
              end
              tsq_pkg::OPT_LIT_CHS: begin
                nxt_s.o.chs_stb = 1'b1;
                nxt_s.o.chs_val = s_ff.r.lit; // see RL12
              end
              tsq_pkg::OPT_BCAST: begin // see RL3
                nxt_s.o.oc1_clk =
                  s_ff.r.bte[tsq_pkg::BTE_OC1_CLK_BIT]; // see RL1
                nxt_s.o.oc_sync = s_ff.r.bte[tsq_pkg::BTE_SYNC_LSB +:
                                             tsq_pkg::BTE_SYNC_N]; // see RL2
              end
              default: nxt_s.wtmr = 2'b00;
            endcase
          end else if (cmd == tsq_pkg::CMD_ADD) begin
            // add when opt[3]=0 under code 1, copy when opt[3]=1
            src = opt[3] ? s_ff.r.hold : s_ff.r.adj; // see RL10 RL11
            case (opt[2:0])
              tsq_pkg::TGT_C0: cur = s_ff.r.c0lim;
              tsq_pkg::TGT_C1: cur = s_ff.r.c1lim;
              tsq_pkg::TGT_T0: cur = s_ff.r.t0lim;
              tsq_pkg::TGT_T1: cur = s_ff.r.t1lim;
              tsq_pkg::TGT_SD: cur = s_ff.r.sdlim;
              tsq_pkg::TGT_LIT: cur = s_ff.r.lit;
              default: cur = 16'h0000;
            endcase
            newv = opt[3] ? src : 16'(cur + src);
            case (opt[2:0])
              tsq_pkg::TGT_C0: nxt_s.r.c0lim = newv;
              tsq_pkg::TGT_C1: nxt_s.r.c1lim = newv;
              tsq_pkg::TGT_T0: nxt_s.r.t0lim = newv;
              tsq_pkg::TGT_T1: nxt_s.r.t1lim = newv;
              tsq_pkg::TGT_SD: nxt_s.r.sdlim = newv;
              tsq_pkg::TGT_LIT: nxt_s.r.lit = newv;
              default: nxt_s.r.lit = s_ff.r.lit;
            endcase
          end else if (cmd[3:1] == tsq_pkg::CMD_JMP) begin
            nxt_s.qptr = tgt5;
          end else if (cmd[3:1] == tsq_pkg::CMD_JMPC0) begin
            if (s_ff.c0 != s_ff.r.c0lim) begin // see RL8 RL17
              nxt_s.c0 = 16'(s_ff.c0 + 16'h0001);
              nxt_s.qptr = tgt5;
            end else begin
              nxt_s.c0 = 16'h0000;
            end
          end else if (cmd[3:1] == tsq_pkg::CMD_JMPC1) begin
            if (s_ff.c1 != s_ff.r.c1lim) begin // see RL9
              nxt_s.c1 = 16'(s_ff.c1 + 16'h0001);
              nxt_s.qptr = tgt5;
            end else begin
              nxt_s.c1 = 16'h0000;
            end
          end
          // step delay: limit extra cycles after the base cycle
          // the exec cycle is the base cycle, so wait limit cycles: count from limit-1 down to 0
          if ((s_ff.sd_on || (cmd == tsq_pkg::CMD_CTRL &&
                              opt == tsq_pkg::OPT_SD_ON)) &&
              s_ff.r.sdlim != 16'h0000) begin
            nxt_s.dcnt = 16'(s_ff.r.sdlim - 16'h0001); // see RL7
            nxt_s.st = tsq_pkg::ST_WAIT;
          end else if (cmd == tsq_pkg::CMD_CTRL &&
                       (opt == 4'h8 || opt == 4'h9)) begin
            nxt_s.dcnt = 16'h0000;
            nxt_s.st = tsq_pkg::ST_WAIT;
          end
          if (cmd == tsq_pkg::CMD_CTRL && opt == tsq_pkg::OPT_SD_OFF) begin
            nxt_s.st = tsq_pkg::ST_EXEC;
          end
        end
        tsq_pkg::ST_WAIT: begin
          if (s_ff.wtmr == 2'b01 && !timer0_match ||
              s_ff.wtmr == 2'b10 && !timer1_match) begin
            nxt_s.st = tsq_pkg::ST_WAIT;
          end else if (s_ff.dcnt != 16'h0000) begin
            nxt_s.wtmr = 2'b00;
            nxt_s.dcnt = 16'(s_ff.dcnt - 16'h0001); // see RL7
          end else begin
            nxt_s.wtmr = 2'b00;
            nxt_s.st = tsq_pkg::ST_EXEC;
          end
        end
        default: nxt_s.st = tsq_pkg::ST_IDLE;
      endcase
    end
    nxt_s.t0q = nxt_s.r.t0lim;
    nxt_s.t1q = nxt_s.r.t1lim;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.st <= tsq_pkg::ST_IDLE;
      s_ff.wreq <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign avs_readdata = s_ff.rdata;
  // waitrequest low only in the answer cycle; a flop so it is clean
  assign avs_waitrequest = s_ff.wreq;
  assign oc_unit1_clock_pulse = s_ff.o.oc1_clk;
  assign oc_sync_pulse = s_ff.o.oc_sync;
  assign chs_strobe = s_ff.o.chs_stb;
  assign converter_channel_select = s_ff.o.chs_val;
  assign timer0_limit_q = s_ff.t0q;
  assign timer1_limit_q = s_ff.t1q;
endmodule
`default_nettype wire

// ===== src/tsq_pkg.sv
// package: register map, field layout, step encodings and state types
package tsq_pkg;
  localparam int unsigned DATA_W = 16;
  // register word offsets (byte addresses on a 32-bit avalon bus)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BTE = 8'h04;
  localparam logic [7:0] OFF_T0LIM = 8'h08;
  localparam logic [7:0] OFF_T1LIM = 8'h0c;
  localparam logic [7:0] OFF_SDLIM = 8'h10;
  localparam logic [7:0] OFF_C0LIM = 8'h14;
  localparam logic [7:0] OFF_C1LIM = 8'h18;
  localparam logic [7:0] OFF_HOLD = 8'h1c;
  localparam logic [7:0] OFF_ADJ = 8'h20;
  localparam logic [7:0] OFF_LIT = 8'h24;
  localparam logic [7:0] OFF_QPTR = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h2c;
  localparam logic [7:0] OFF_QUE0 = 8'h40;
  localparam int unsigned QUE_REGS = 16;
  // control register fields
  localparam int unsigned CTRL_EN_BIT = 15;
  localparam int unsigned CTRL_RUN_BIT = 7;
  // broadcast enable fields
  localparam int unsigned BTE_OC1_CLK_BIT = 4;
  localparam int unsigned BTE_SYNC_LSB = 0;
  localparam int unsigned BTE_SYNC_N = 4;
  // step pointer field
  localparam int unsigned QPTR_W = 5;
  // step byte fields
  localparam int unsigned STEP_ODD_LSB = 8;
  localparam int unsigned STEP_EVEN_LSB = 0;
  // reset and unmapped read values
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  // command codes (upper nibble)
  localparam logic [3:0] CMD_CTRL = 4'h0;
  localparam logic [3:0] CMD_ADD = 4'h1;
  localparam logic [2:0] CMD_JMP = 3'h5;
  localparam logic [2:0] CMD_JMPC0 = 3'h6;
  localparam logic [2:0] CMD_JMPC1 = 3'h7;
  // control options
  localparam logic [3:0] OPT_SD_OFF = 4'h2;
  localparam logic [3:0] OPT_SD_ON = 4'h6;
  localparam logic [3:0] OPT_C0_CHS = 4'hc;
  localparam logic [3:0] OPT_C1_CHS = 4'hd;
  localparam logic [3:0] OPT_LIT_CHS = 4'he;
  localparam logic [3:0] OPT_BCAST = 4'hf;
  // add/copy targets (low three option bits, bit 3 picks copy)
  localparam logic [2:0] TGT_C0 = 3'h0;
  localparam logic [2:0] TGT_C1 = 3'h1;
  localparam logic [2:0] TGT_T0 = 3'h2;
  localparam logic [2:0] TGT_T1 = 3'h3;
  localparam logic [2:0] TGT_SD = 3'h4;
  localparam logic [2:0] TGT_LIT = 3'h5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b100
  } tsq_seq_t;

  typedef struct packed {
    logic [15:0] bte;
    logic [15:0] t0lim;
    logic [15:0] t1lim;
    logic [15:0] sdlim;
    logic [15:0] c0lim;
    logic [15:0] c1lim;
    logic [15:0] hold;
    logic [15:0] adj;
    logic [15:0] lit;
  } tsq_regs_t;

  typedef struct packed {
    logic oc1_clk;
    logic [3:0] oc_sync;
    logic chs_stb;
    logic [15:0] chs_val;
  } tsq_out_t;
endpackage

// ===== src/tsq_step_queue.sv
// step queue storage: sixteen pair words, byte fetch by step index
`timescale 1ns/10ps
`default_nettype none
module tsq_step_queue #(
  parameter int unsigned NREG = tsq_pkg::QUE_REGS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // software write and read port
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data,
  // sequencer fetch port
  input wire logic [4:0] step_idx,
  output logic [7:0] step_byte
);
  logic [15:0] mem_ff [NREG];
  logic [15:0] pair;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_q
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          mem_ff[g] <= tsq_pkg::RST_REG; // see RL15
        end else if (wr_en && wr_idx == 4'(g)) begin
          mem_ff[g] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = mem_ff[rd_idx];
  assign pair = mem_ff[step_idx[4:1]];
  // odd step in high byte, even step in low byte
  assign step_byte = step_idx[0] ? pair[tsq_pkg::STEP_ODD_LSB +: 8]
                                 : pair[tsq_pkg::STEP_EVEN_LSB +: 8]; // see RL14
endmodule
`default_nettype wire

// ===== sim/tsq_regs_props.sv
// checker: port-level properties of the parameter bank
`timescale 1ns/10ps
`default_nettype none
module tsq_regs_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // trigger outputs and limits
  input wire logic oc_unit1_clock_pulse,
  input wire logic [3:0] oc_sync_pulse,
  input wire logic chs_strobe,
  input wire logic [15:0] timer0_limit_q,
  input wire logic [15:0] timer1_limit_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic rd_ans = avs_read && !avs_waitrequest;
  ////////////////////////////////////////////////////////////////////////////
  chk_answer_next: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  chk_answer_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  chk_no_spurious: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("bus answer without request");
  chk_pointer_upper: assert property (
    rd_ans && avs_address == tsq_pkg::OFF_QPTR |-> avs_readdata[31:5] == 27'h0)
    else $error("pointer upper bits not zero");
  chk_unmapped_zero: assert property (
    rd_ans && (avs_address inside {[8'h30:8'h3c]} || avs_address >= 8'h80)
    |-> avs_readdata == tsq_pkg::UNMAPPED_RD)
    else $error("unmapped read not zero");
  chk_t0_view: assert property (
    rd_ans && avs_address == tsq_pkg::OFF_T0LIM
    |-> avs_readdata[15:0] == timer0_limit_q)
    else $error("timer 0 limit output differs");
  chk_t1_view: assert property (
    rd_ans && avs_address == tsq_pkg::OFF_T1LIM
    |-> avs_readdata[15:0] == timer1_limit_q)
    else $error("timer 1 limit output differs");
  chk_clock_pulse: assert property (
    oc_unit1_clock_pulse |=> !oc_unit1_clock_pulse)
    else $error("clock pulse too wide");
  chk_sync_pulse: assert property (
    |oc_sync_pulse |=> oc_sync_pulse == 4'h0)
    else $error("sync pulse too wide");
  chk_chs_pulse: assert property (
    chs_strobe |=> !chs_strobe)
    else $error("select strobe too wide");
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> avs_waitrequest && !chs_strobe && oc_sync_pulse == 4'h0)
    else $error("outputs active after reset");
  cover property (oc_unit1_clock_pulse);
  cover property (chs_strobe);
  cover property (avs_write && !avs_waitrequest);
endmodule
bind tsq_regs tsq_regs_props u_props (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .oc_unit1_clock_pulse(oc_unit1_clock_pulse), .oc_sync_pulse(oc_sync_pulse),
  .chs_strobe(chs_strobe), .timer0_limit_q(timer0_limit_q),
  .timer1_limit_q(timer1_limit_q));
`default_nettype wire

// ===== sim/tb_top.sv
// testbench: register access, lock and step execution of the bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic timer0_match, timer1_match, oc_unit1_clock_pulse, chs_strobe;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, seed;
  logic [3:0] avs_byteenable, oc_sync_pulse;
  logic [15:0] converter_channel_select, timer0_limit_q, timer1_limit_q;
  logic [15:0] chs_first, chs_last, d, c0, sd, hold, adj, bte;
  int miscompares = 0, tests_run = 0, cyc = 0, oc1_cnt, chs_cnt, p0, p1;
  int sync_cnt [4];
  tsq_regs u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .oc_unit1_clock_pulse(oc_unit1_clock_pulse), .oc_sync_pulse(oc_sync_pulse),
    .chs_strobe(chs_strobe),
    .converter_channel_select(converter_channel_select),
    .timer0_match(timer0_match), .timer1_match(timer1_match),
    .timer0_limit_q(timer0_limit_q), .timer1_limit_q(timer1_limit_q));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // pulse monitor, cleared by reset so each run starts from zero
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sys_rst === 1'b1) begin
      oc1_cnt <= 0;
      chs_cnt <= 0;
      for (int i = 0; i < 4; i++) sync_cnt[i] <= 0;
    end else begin
      if (oc_unit1_clock_pulse === 1'b1) begin
        if (oc1_cnt == 0) p0 <= cyc;
        if (oc1_cnt == 1) p1 <= cyc;
        oc1_cnt <= oc1_cnt + 1;
      end
      for (int i = 0; i < 4; i++)
        if (oc_sync_pulse[i] === 1'b1) sync_cnt[i] <= sync_cnt[i] + 1;
      if (chs_strobe === 1'b1) begin
        if (chs_cnt == 0) chs_first <= converter_channel_select;
        chs_last <= converter_channel_select;
        chs_cnt <= chs_cnt + 1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until the edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, v};
    timer0_match <= 1'($urandom);
    timer1_match <= 1'($urandom);
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [31:0] exp_rd(input logic [7:0] a,
                                         input logic [15:0] v);
    if (a == tsq_pkg::OFF_QPTR) return {27'h0, v[4:0]};
    // status word: sequencer idle, counter 1 at zero
    if (a == tsq_pkg::OFF_STAT) return {13'h0, tsq_pkg::ST_IDLE, 16'h0000};
    if (a > tsq_pkg::OFF_STAT && a < tsq_pkg::OFF_QUE0 || a >= 8'h80)
      return tsq_pkg::UNMAPPED_RD;
    return {16'h0000, v};
  endfunction
  // reset, load queue and limits, start, then try a write while locked
  task automatic run(input logic [63:0] q);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      bus(1'b1, tsq_pkg::OFF_QUE0 + 8'(4 * i), q[16 * i +: 16]);
    bus(1'b1, tsq_pkg::OFF_C0LIM, c0);
    bus(1'b1, tsq_pkg::OFF_C1LIM, c0);
    bus(1'b1, tsq_pkg::OFF_SDLIM, sd);
    bus(1'b1, tsq_pkg::OFF_HOLD, hold);
    bus(1'b1, tsq_pkg::OFF_ADJ, adj);
    bus(1'b1, tsq_pkg::OFF_BTE, bte);
    bus(1'b1, tsq_pkg::OFF_CTRL, 16'h8000);
    bus(1'b1, tsq_pkg::OFF_CTRL, 16'h8080);
    repeat (150) @(posedge clk);
    bus(1'b1, tsq_pkg::OFF_HOLD, ~hold);
    bus(1'b0, tsq_pkg::OFF_HOLD, 16'h0000);
    chk(rd, {16'h0000, hold});
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    timer0_match = 1'b0;
    timer1_match = 1'b0;
    seed = $urandom(5);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 4; a < 132; a += 4) begin
      bus(1'b0, 8'(a), 16'h0000);
      chk(rd, exp_rd(8'(a), 16'h0000));
    end
    for (int a = 4; a < 132; a += 4) begin
      d = 16'($urandom);
      bus(1'b1, 8'(a), d);
      bus(1'b0, 8'(a), 16'h0000);
      chk(rd, exp_rd(8'(a), d));
      if (a == 8) chk(32'(timer0_limit_q), 32'(d));
      if (a == 12) chk(32'(timer1_limit_q), 32'(d));
    end
    c0 = 16'(1 + $urandom % 5);
    sd = 16'h0000;
    hold = 16'($urandom);
    adj = 16'($urandom);
    bte = 16'($urandom % 32);
    run({16'h00a6, 16'h0e15, 16'h0e1d, 16'hc00f});
    chk(oc1_cnt, bte[4] ? c0 + 1 : 0);
    for (int i = 0; i < 4; i++)
      chk(sync_cnt[i], bte[i] ? c0 + 1 : 0);
    chk(chs_cnt, 2);
    chk(32'(chs_first), 32'(hold));
    chk(32'(chs_last), 32'(16'(hold + adj)));
    sd = 16'(1 + $urandom % 4);
    bte = 16'h001f;
    run({16'h0000, 16'h00a4, 16'he10c, 16'h0f06});
    chk(oc1_cnt, c0 + 1);
    chk(p1 - p0, 3 * (sd + 1));
    chk(32'(chs_last), 32'(c0));
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
